// *** logic_rotate_return_exec.sv ***
`timescale 1ns/100ps
module logic_rotate_return_exec
  import exec_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic            rst_b_i,
  input  wire logic            op_valid_i,
  input  wire exec_op_t        op_i,
  input  wire logic [7:0]      imm_i,
  input  wire logic [7:0]      mem_rdata_i,
  input  wire logic [PC_W-1:0] stack_top_i,
  input  wire logic            irq_pending_i,
  input  wire logic            irq_ctrl_wr_i,
  input  wire logic [7:0]      irq_ctrl_wdata_i,
  input  wire logic            work_wr_i,
  input  wire logic [7:0]      work_wdata_i,
  output logic      [7:0]      work_register_o,
  output logic                 zero_flag_o,
  output logic                 mem_wr_o,
  output logic      [7:0]      mem_wdata_o,
  output logic                 stack_pop_o,
  output logic                 pc_load_o,
  output logic      [PC_W-1:0] pc_o,
  output logic                 irq_enter_o,
  output logic      [PC_W-1:0] irq_return_addr_o,
  output logic      [7:0]      irq_control_reg_o,
  output logic                 global_irq_enable_o
);

  // ==========================================================================
  // State
  logic [7:0]      work_r,     work_nxt;
  logic            zero_r,     zero_nxt;
  logic            mem_wr_r,   mem_wr_nxt;
  logic [7:0]      mem_wd_r,   mem_wd_nxt;
  logic            pop_r,      pop_nxt;
  logic            pc_load_r,  pc_load_nxt;
  logic [PC_W-1:0] pc_r,       pc_nxt;
  logic            irq_ent_r,  irq_ent_nxt;
  logic [PC_W-1:0] ret_addr_r, ret_addr_nxt;
  logic [7:0]      ictl_r,     ictl_nxt;

  logic [7:0]      or_mem;
  logic            or_mem_zero;
  logic [7:0]      rot_mem;
  logic [7:0]      or_imm;
  logic            or_imm_zero;

  // ==========================================================================
  // Datapath
  byte_alu #(.W(DATA_W)) u_mem_alu (
    .a_i       (work_r),
    .b_i       (mem_rdata_i),
    .or_o      (or_mem),
    .or_zero_o (or_mem_zero),
    .rotl_o    (rot_mem)
  );

  byte_alu #(.W(DATA_W)) u_imm_alu (
    .a_i       (work_r),
    .b_i       (imm_i),
    .or_o      (or_imm),
    .or_zero_o (or_imm_zero),
    .rotl_o    ()
  );

  // ==========================================================================
  // Next state
  always_comb begin
    work_nxt     = work_r;
    zero_nxt     = zero_r;
    mem_wr_nxt   = 1'b0;
    mem_wd_nxt   = mem_wd_r;
    pop_nxt      = 1'b0;
    pc_load_nxt  = 1'b0;
    pc_nxt       = pc_r;
    irq_ent_nxt  = 1'b0;
    ret_addr_nxt = ret_addr_r;
    ictl_nxt     = ictl_r;
    if (irq_ctrl_wr_i) begin
      ictl_nxt = irq_ctrl_wdata_i;
    end
    if (work_wr_i) begin
      work_nxt = work_wdata_i;
    end
    if (op_valid_i) begin
      unique case (op_i)
        OP_IDLE: begin
        end
        OP_BITWISE_MERGE_IMM: begin
          work_nxt = or_imm;
          zero_nxt = or_imm_zero;
        end
        OP_BITWISE_MERGE_TO_MEM: begin
          mem_wr_nxt = 1'b1;
          mem_wd_nxt = or_mem;
          zero_nxt   = or_mem_zero;
        end
        OP_SUBROUTINE_EXIT: begin
          pop_nxt     = 1'b1;
          pc_load_nxt = 1'b1;
          pc_nxt      = stack_top_i;
        end
        OP_SUBROUTINE_EXIT_LOAD_IMM: begin
          pop_nxt     = 1'b1;
          pc_load_nxt = 1'b1;
          pc_nxt      = stack_top_i;
          work_nxt    = imm_i;
        end
        OP_ISR_EXIT_RESTORE: begin
          pop_nxt           = 1'b1;
          ictl_nxt[GIE_BIT] = 1'b1;
          // A pending request takes over here, so the restored address is
          // handed to the core as the return address instead of being jumped
          // to; the main program resumes when that routine exits.
          if (irq_pending_i) begin
            irq_ent_nxt  = 1'b1;
            ret_addr_nxt = stack_top_i;
          end else begin
            pc_load_nxt = 1'b1;
            pc_nxt      = stack_top_i;
          end
        end
        OP_CIRCULAR_SHIFT_MEM: begin
          mem_wr_nxt = 1'b1;
          mem_wd_nxt = rot_mem;
        end
        OP_ROTATE_TO_WORK: begin
          work_nxt = rot_mem;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      work_r     <= WORK_RST;
      zero_r     <= ZERO_RST;
      mem_wr_r   <= 1'b0;
      mem_wd_r   <= 8'h00;
      pop_r      <= 1'b0;
      pc_load_r  <= 1'b0;
      pc_r       <= PC_RST;
      irq_ent_r  <= 1'b0;
      ret_addr_r <= PC_RST;
      ictl_r     <= IRQ_CTRL_RST;
    end else begin
      work_r     <= work_nxt;
      zero_r     <= zero_nxt;
      mem_wr_r   <= mem_wr_nxt;
      mem_wd_r   <= mem_wd_nxt;
      pop_r      <= pop_nxt;
      pc_load_r  <= pc_load_nxt;
      pc_r       <= pc_nxt;
      irq_ent_r  <= irq_ent_nxt;
      ret_addr_r <= ret_addr_nxt;
      ictl_r     <= ictl_nxt;
    end
  end

  assign work_register_o     = work_r;
  assign zero_flag_o         = zero_r;
  assign mem_wr_o            = mem_wr_r;
  assign mem_wdata_o         = mem_wd_r;
  assign stack_pop_o         = pop_r;
  assign pc_load_o           = pc_load_r;
  assign pc_o                = pc_r;
  assign irq_enter_o         = irq_ent_r;
  assign irq_return_addr_o   = ret_addr_r;
  assign irq_control_reg_o   = ictl_r;
  assign global_irq_enable_o = ictl_r[GIE_BIT];

  // ==========================================================================
  // Checks
  property p_merge_imm;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && op_i == OP_BITWISE_MERGE_IMM && !work_wr_i |=>
        work_register_o == ($past(work_register_o) | $past(imm_i));
  endproperty
  a_merge_imm: assert property (p_merge_imm)
    else $error("merge immediate result wrong");

  property p_merge_mem;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && op_i == OP_BITWISE_MERGE_TO_MEM && !work_wr_i |=>
        mem_wr_o
        && mem_wdata_o == ($past(work_register_o) | $past(mem_rdata_i))
        && work_register_o == $past(work_register_o);
  endproperty
  a_merge_mem: assert property (p_merge_mem)
    else $error("merge to memory result wrong");

  property p_sub_exit;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && op_i == OP_SUBROUTINE_EXIT |=>
        pc_load_o && stack_pop_o && pc_o == $past(stack_top_i)
        && $stable(zero_flag_o);
  endproperty
  a_sub_exit: assert property (p_sub_exit)
    else $error("subroutine exit did not restore counter");

  property p_sub_exit_imm;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && op_i == OP_SUBROUTINE_EXIT_LOAD_IMM && !work_wr_i |=>
        pc_load_o && stack_pop_o && pc_o == $past(stack_top_i)
        && work_register_o == $past(imm_i) && $stable(zero_flag_o);
  endproperty
  a_sub_exit_imm: assert property (p_sub_exit_imm)
    else $error("subroutine exit with load wrong");

  property p_isr_exit;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && op_i == OP_ISR_EXIT_RESTORE && !irq_ctrl_wr_i |=>
        global_irq_enable_o && stack_pop_o && $stable(zero_flag_o);
  endproperty
  a_isr_exit: assert property (p_isr_exit)
    else $error("interrupt exit did not set global enable");

  property p_isr_pending;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && op_i == OP_ISR_EXIT_RESTORE && irq_pending_i |=>
        irq_enter_o && !pc_load_o
        && irq_return_addr_o == $past(stack_top_i);
  endproperty
  a_isr_pending: assert property (p_isr_pending)
    else $error("pending interrupt not entered before resuming");

  property p_rot_mem;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && op_i == OP_CIRCULAR_SHIFT_MEM |=>
        mem_wr_o && mem_wdata_o[0] == $past(mem_rdata_i[7])
        && mem_wdata_o[7:1] == $past(mem_rdata_i[6:0]) && $stable(zero_flag_o);
  endproperty
  a_rot_mem: assert property (p_rot_mem)
    else $error("memory rotate result wrong");

  property p_rot_work;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && op_i == OP_ROTATE_TO_WORK && !work_wr_i |=>
        !mem_wr_o && work_register_o == {$past(mem_rdata_i[6:0]),
        $past(mem_rdata_i[7])} && $stable(zero_flag_o);
  endproperty
  a_rot_work: assert property (p_rot_work)
    else $error("rotate to work register wrong");

  property p_zero;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      op_valid_i && (op_i == OP_BITWISE_MERGE_IMM
        || op_i == OP_BITWISE_MERGE_TO_MEM) |=>
        zero_flag_o == (($past(op_i) == OP_BITWISE_MERGE_IMM) ?
          (work_register_o == 8'h00) : (mem_wdata_o == 8'h00));
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag does not match result");

endmodule // logic_rotate_return_exec

// *** exec_pkg.sv ***
// Contract
// - Merge immediate: work register ORed with immediate; zero updated.
// - Merge to memory: byte ORed with work register; zero updated.
// - Subroutine exit pops the stack into the counter; flags untouched.
// - Exit with load pops counter, loads immediate into work register.
// - Interrupt exit pops counter and sets global enable, control bit 0.
// - A pending interrupt is serviced before the restored address resumes.
// - Memory rotate left: bit i to i+1, bit 7 to 0, stored back.
// - Rotate to work: rotated byte to work; memory and flags kept.
package exec_pkg;

  // ==========================================================================
  // Widths and reset values
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PC_W          = 16;
  localparam logic [7:0]  WORK_RST      = 8'h00;
  localparam logic        ZERO_RST      = 1'b0;
  localparam logic        GIE_RST       = 1'b0;
  localparam logic [15:0] PC_RST        = 16'h0000;
  localparam int unsigned GIE_BIT       = 0;
  localparam logic [7:0]  IRQ_CTRL_RST  = 8'h00;

  // ==========================================================================
  // Operation codes presented by the decoder
  typedef enum logic [2:0] {
    OP_IDLE                     = 3'b000,
    OP_BITWISE_MERGE_IMM        = 3'b001,
    OP_BITWISE_MERGE_TO_MEM     = 3'b010,
    OP_SUBROUTINE_EXIT          = 3'b011,
    OP_SUBROUTINE_EXIT_LOAD_IMM = 3'b100,
    OP_ISR_EXIT_RESTORE         = 3'b101,
    OP_CIRCULAR_SHIFT_MEM       = 3'b110,
    OP_ROTATE_TO_WORK           = 3'b111
  } exec_op_t;

endpackage

// *** byte_alu.sv ***
`timescale 1ns/100ps
module byte_alu #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] a_i,
  input  wire logic [W-1:0] b_i,
  output logic      [W-1:0] or_o,
  output logic              or_zero_o,
  output logic      [W-1:0] rotl_o
);

  // ==========================================================================
  // Merge and rotate datapath
  assign or_o      = a_i | b_i;
  assign or_zero_o = ~|or_o;
  assign rotl_o    = {b_i[W-2:0], b_i[W-1]};

endmodule // byte_alu

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
  import exec_pkg::*;

  // ==========================================================================
  // Stimulus and observed signals
  logic             sys_clk_i;
  logic             rst_b_i;
  logic             op_valid_i;
  exec_op_t         op_i;
  logic [7:0]       imm_i;
  logic [7:0]       mem_rdata_i;
  logic [PC_W-1:0]  stack_top_i;
  logic             irq_pending_i;
  logic             irq_ctrl_wr_i;
  logic [7:0]       irq_ctrl_wdata_i;
  logic             work_wr_i;
  logic [7:0]       work_wdata_i;
  logic [7:0]       work_register_o;
  logic             zero_flag_o;
  logic             mem_wr_o;
  logic [7:0]       mem_wdata_o;
  logic             stack_pop_o;
  logic             pc_load_o;
  logic [PC_W-1:0]  pc_o;
  logic             irq_enter_o;
  logic [PC_W-1:0]  irq_return_addr_o;
  logic [7:0]       irq_control_reg_o;
  logic             global_irq_enable_o;
  int               n_errors;
  int               checks;

  logic_rotate_return_exec logic_rotate_return_exec_inst (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .imm_i(imm_i), .mem_rdata_i(mem_rdata_i),
    .stack_top_i(stack_top_i), .irq_pending_i(irq_pending_i),
    .irq_ctrl_wr_i(irq_ctrl_wr_i), .irq_ctrl_wdata_i(irq_ctrl_wdata_i),
    .work_wr_i(work_wr_i), .work_wdata_i(work_wdata_i),
    .work_register_o(work_register_o), .zero_flag_o(zero_flag_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
    .irq_enter_o(irq_enter_o), .irq_return_addr_o(irq_return_addr_o),
    .irq_control_reg_o(irq_control_reg_o),
    .global_irq_enable_o(global_irq_enable_o));

  // ==========================================================================
  // Clock, shared tasks
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Presents one op for one edge; outputs are sampled mid-cycle after it.
  task automatic issue(input exec_op_t op, input logic [7:0] imm, mem,
                       input logic [15:0] stk, input logic pend);
    @(posedge sys_clk_i);
    op_valid_i    <= 1'b1;
    op_i          <= op;
    imm_i         <= imm;
    mem_rdata_i   <= mem;
    stack_top_i   <= stk;
    irq_pending_i <= pend;
    @(posedge sys_clk_i);
    op_valid_i    <= 1'b0;
    irq_pending_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask

  // Side loads of the work register (w=1) or interrupt control (w=0).
  task automatic side_load(input logic w, input logic [7:0] v);
    @(posedge sys_clk_i);
    work_wr_i        <= w;
    work_wdata_i     <= v;
    irq_ctrl_wr_i    <= ~w;
    irq_ctrl_wdata_i <= v;
    @(posedge sys_clk_i);
    work_wr_i     <= 1'b0;
    irq_ctrl_wr_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_merge();
    side_load(1'b1, 8'h50);
    issue(OP_BITWISE_MERGE_IMM, 8'h0a, 8'hff, 16'h0000, 1'b0);
    chk("work", 16'h005a, {8'h00, work_register_o});
    chk("zero", 16'h0000, {15'h0000, zero_flag_o});
    side_load(1'b1, 8'h00);
    issue(OP_BITWISE_MERGE_IMM, 8'h00, 8'hff, 16'h0000, 1'b0);
    chk("zero", 16'h0001, {15'h0000, zero_flag_o});
    side_load(1'b1, 8'h0f);
    issue(OP_BITWISE_MERGE_TO_MEM, 8'h00, 8'hf0, 16'h0000, 1'b0);
    chk("mem_wr", 16'h0001, {15'h0000, mem_wr_o});
    chk("mem_wdata", 16'h00ff, {8'h00, mem_wdata_o});
    chk("work", 16'h000f, {8'h00, work_register_o});
    chk("zero", 16'h0000, {15'h0000, zero_flag_o});
    $display("test merge done");
  endtask

  // The zero flag is set first so that a flag-preserving op that clears it
  // would be caught.
  task automatic t_returns();
    side_load(1'b1, 8'h00);
    issue(OP_BITWISE_MERGE_IMM, 8'h00, 8'h00, 16'h0000, 1'b0);
    chk("zero", 16'h0001, {15'h0000, zero_flag_o});
    issue(OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 16'h1234, 1'b0);
    chk("pop", 16'h0001, {15'h0000, stack_pop_o});
    chk("pc_load", 16'h0001, {15'h0000, pc_load_o});
    chk("pc", 16'h1234, pc_o);
    chk("zero", 16'h0001, {15'h0000, zero_flag_o});
    issue(OP_SUBROUTINE_EXIT_LOAD_IMM, 8'h5c, 8'h00, 16'habcd, 1'b0);
    chk("pc", 16'habcd, pc_o);
    chk("pop", 16'h0001, {15'h0000, stack_pop_o});
    chk("work", 16'h005c, {8'h00, work_register_o});
    chk("zero", 16'h0001, {15'h0000, zero_flag_o});
    issue(OP_ISR_EXIT_RESTORE, 8'h00, 8'h00, 16'h0456, 1'b0);
    chk("gie", 16'h0001, {15'h0000, global_irq_enable_o});
    chk("ctrl", 16'h0001, {8'h00, irq_control_reg_o});
    chk("pc", 16'h0456, pc_o);
    chk("enter", 16'h0000, {15'h0000, irq_enter_o});
    side_load(1'b0, 8'h00);
    chk("gie", 16'h0000, {15'h0000, global_irq_enable_o});
    issue(OP_ISR_EXIT_RESTORE, 8'h00, 8'h00, 16'h0789, 1'b1);
    chk("enter", 16'h0001, {15'h0000, irq_enter_o});
    chk("ret_addr", 16'h0789, irq_return_addr_o);
    chk("pc_load", 16'h0000, {15'h0000, pc_load_o});
    chk("pop", 16'h0001, {15'h0000, stack_pop_o});
    chk("gie", 16'h0001, {15'h0000, global_irq_enable_o});
    chk("zero", 16'h0001, {15'h0000, zero_flag_o});
    $display("test returns done");
  endtask

  task automatic t_rotate();
    issue(OP_CIRCULAR_SHIFT_MEM, 8'h00, 8'h81, 16'h0000, 1'b0);
    chk("mem_wr", 16'h0001, {15'h0000, mem_wr_o});
    chk("mem_wdata", 16'h0003, {8'h00, mem_wdata_o});
    issue(OP_CIRCULAR_SHIFT_MEM, 8'h00, 8'h00, 16'h0000, 1'b0);
    chk("zero", 16'h0001, {15'h0000, zero_flag_o});
    issue(OP_ROTATE_TO_WORK, 8'h00, 8'hc1, 16'h0000, 1'b0);
    chk("work", 16'h0083, {8'h00, work_register_o});
    chk("mem_wr", 16'h0000, {15'h0000, mem_wr_o});
    chk("zero", 16'h0001, {15'h0000, zero_flag_o});
    issue(OP_IDLE, 8'hff, 8'hff, 16'hffff, 1'b1);
    chk("idle_work", 16'h0083, {8'h00, work_register_o});
    chk("idle_mem_wr", 16'h0000, {15'h0000, mem_wr_o});
    chk("idle_pop", 16'h0000, {15'h0000, stack_pop_o});
    chk("idle_pc_load", 16'h0000, {15'h0000, pc_load_o});
    chk("idle_enter", 16'h0000, {15'h0000, irq_enter_o});
    $display("test rotate done");
  endtask

  // Reset in mid-run must clear the work register, zero flag, global enable,
  // counter and return address, and the first op after the release must be taken normally.
  task automatic t_reset();
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("rst_work", 16'h0000, {8'h00, work_register_o});
    chk("rst_zero", 16'h0000, {15'h0000, zero_flag_o});
    chk("rst_gie", 16'h0000, {15'h0000, global_irq_enable_o});
    chk("rst_pc", 16'h0000, pc_o);
    chk("rst_ret_addr", 16'h0000, irq_return_addr_o);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    issue(OP_BITWISE_MERGE_IMM, 8'h3c, 8'h00, 16'h0000, 1'b0);
    chk("work", 16'h003c, {8'h00, work_register_o});
    chk("zero", 16'h0000, {15'h0000, zero_flag_o});
    $display("test reset done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    n_errors = 0;
    checks = 0;
    rst_b_i = 1'b0;
    op_valid_i = 1'b0;
    op_i = OP_IDLE;
    imm_i = 8'h00;
    mem_rdata_i = 8'h00;
    stack_top_i = 16'h0000;
    irq_pending_i = 1'b0;
    irq_ctrl_wr_i = 1'b0;
    irq_ctrl_wdata_i = 8'h00;
    work_wr_i = 1'b0;
    work_wdata_i = 8'h00;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_merge();
    t_returns();
    t_rotate();
    t_reset();
    summarize();
  end

  // The whole run needs well under a hundred cycles.
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    n_errors++;
    summarize();
  end

endmodule // tb
